// ---- hdl/dps_pkg.sv ----
/*
 * Constants for the drive protection supervisor: register map, field
 * layouts, reset values, fault and alarm codes, timing scale.
 * Assumes a 40 MHz pclk and an APB master with 32-bit data.
 */
// Overview of operation
// (R1) Overload pre-alarm after current exceeds level for delay
// (R2) Phase-loss select: 0 off,1 out,2 in,3 both
// (R3) Input phase loss: fault, coast after delay
// (R4) Output phase loss above reference: fault after 5 s
// (R5) Imbalance ratio over coefficient 10 s: phase fault
// (R6) Feedback-loss action: none, hold, fault, decelerate
// (R7) Feedback below level for time applies action
// (R8) Serial action: fault coast, alarm run, alarm stop
// (R9) Serial silence past timeout flags link; 0 disables
// (R10) Keypad silence past timeout flags keypad fault
// (R11) Store error: 0 fault coast, 1 alarm run
// (R12) Overload mode 2 current over threshold: fault
// (R13) Overcurrent/module faults over limit block reset
// (R14) Station address 0..247, 0 is broadcast
// (R15) Broadcast address executes but never replies
// (R16) Timers restart when condition drops early
// (R17) Faults latch and hold stop until reset
package dps_pkg;
	localparam int unsigned CLK_HZ       = 40_000_000;
	// Timers tick in tenths of a second
	localparam int unsigned TICK_MS      = 100;
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] OPL_DELAY_T  = 16'h0032; // 5.0 s
	localparam logic [15:0] IMB_DELAY_T  = 16'h0064; // 10.0 s
	localparam logic [15:0] COEF_OFF     = 16'h0064; // 1.00 in hundredths

	// Register byte addresses
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_LIMA   = 8'h04;
	localparam logic [7:0] A_LIMB   = 8'h08;
	localparam logic [7:0] A_TIMA   = 8'h0c;
	localparam logic [7:0] A_TIMB   = 8'h10;
	localparam logic [7:0] A_TIMC   = 8'h14;
	localparam logic [7:0] A_STAT   = 8'h18;
	localparam logic [7:0] A_MASK   = 8'h1c;
	localparam logic [7:0] A_FAULT  = 8'h20;
	localparam logic [7:0] A_CMD    = 8'h24;

	// Control register reset: addr 1, phase 3, pid 0, serial 1, keypad 1,
	// store 0, overload mode 0
	localparam logic [31:0] CTRL_RST = 32'h0001_4301;
	// Limits A: prealarm 160 %, output phase ref 50 %
	localparam logic [31:0] LIMA_RST = 32'h0032_00a0;
	// Limits B: drive overload 150 %, imbalance coef 1.00
	localparam logic [31:0] LIMB_RST = 32'h0064_0096;
	// Times A: prealarm 10.0 s, input phase 1.0 s
	localparam logic [31:0] TIMA_RST = 32'h0064_000a;
	// Times B: pid 10.0 s, serial 5.0 s
	localparam logic [31:0] TIMB_RST = 32'h0032_0064;
	// Times C: keypad 1.0 s, drive overload 60 s
	localparam logic [31:0] TIMC_RST = 32'h0258_000a;
	localparam logic [13:0] OCLIM_RST = 14'h0005;

	// Event / status bit positions
	localparam int EV_PRE = 0;
	localparam int EV_INP = 1;
	localparam int EV_OUTP = 2;
	localparam int EV_PID = 3;
	localparam int EV_SER = 4;
	localparam int EV_KEY = 5;
	localparam int EV_NVS = 6;
	localparam int EV_OVL = 7;
	localparam int NEV   = 8;

	// Fault codes shown
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_PRE  = 8'h09; // alarm A-09
	localparam logic [7:0] CODE_OVL  = 8'h09; // fault E-09
	localparam logic [7:0] CODE_INP  = 8'h0c;
	localparam logic [7:0] CODE_OUTP = 8'h0d;

	localparam logic [1:0] STOP_NONE  = 2'h0;
	localparam logic [1:0] STOP_COAST = 2'h1;
	localparam logic [1:0] STOP_RAMP  = 2'h2;
	localparam logic [1:0] STOP_HOLD  = 2'h3;
	localparam logic [7:0] ADDR_MAX   = 8'hf7;
endpackage : dps_pkg

// ---- hdl/drive_protection_supervisor.sv ----
/*
 * Drive protection supervisor: duration-qualified protection timers,
 * fault/alarm latching, stop selection and an APB register file.
 * Assumes measurement words arrive synchronous to pclk as percentages of
 * rated current; single-bit event pins may be asynchronous and are filtered.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_protection_supervisor import dps_pkg::*; #(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Measurements, percent of rated current
	input  wire logic [15:0] out_current,
	input  wire logic [15:0] phase_max,
	input  wire logic [15:0] phase_min,
	input  wire logic [15:0] pid_feedback,
	input  wire logic [15:0] pid_max,
	// Detector events
	input  wire logic        in_phase_lost,
	input  wire logic        out_phase_lost,
	input  wire logic        serial_good,
	input  wire logic        keypad_good,
	input  wire logic        nvs_error,
	input  wire logic        overcurrent_fault,
	input  wire logic        module_fault,
	// Supervisor outputs
	output logic             prealarm,
	output logic             alarm,
	output logic             fault,
	output logic [1:0]       stop_mode,
	output logic [7:0]       fault_code,
	output logic             reply_enable,
	output logic             irq
);
	logic [31:0] ctrl_r, lima_r, limb_r, tima_r, timb_r, timc_r;
	logic [NEV-1:0] stat_r, mask_r, cond, ev;
	logic [NEV-1:0] lat_r;
	logic [15:0] tim_r [NEV];
	logic [15:0] lim [NEV];
	logic [23:0] div_r;
	logic        tick;
	logic [13:0] oc_cnt_r, oc_lim_r;
	logic        reset_locked_r, ocm_d_r;
	logic [7:0]  code_r;
	logic [1:0]  stop_r;
	logic        wr, rd, reset_cmd;
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_raw, pin_s1_r, pin_s2_r, pin_s3_r, pin_agree, pin_f_r;
	logic        in_lost_f, out_lost_f, ser_silent_f, key_silent_f, nvs_err_f, oc_f, mod_f;

	wire [7:0] st_addr = ctrl_r[7:0];
	wire [1:0] ph_sel  = ctrl_r[9:8];
	wire [1:0] pid_act = ctrl_r[13:12];
	wire [1:0] ser_act = ctrl_r[15:14];
	wire [1:0] key_act = ctrl_r[17:16];
	wire       nvs_act = ctrl_r[18];
	wire [1:0] ovl_md  = ctrl_r[21:20];
	wire [15:0] pid_lvl = {8'h00, ctrl_r[31:24]};

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign reset_cmd = wr && paddr == A_CMD && pwdata[0];

	// Event pins cross three flops; a level counts once stages two and three
	// agree, so a single-cycle glitch never reaches the timers or the counter
	assign pin_raw = {module_fault, overcurrent_fault, nvs_error, !keypad_good,
		!serial_good, out_phase_lost, in_phase_lost};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_f_r  <= '0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r  <= (pin_f_r & ~pin_agree) | (pin_s3_r & pin_agree);
		end
	end
	assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
	assign {mod_f, oc_f, nvs_err_f, key_silent_f, ser_silent_f, out_lost_f, in_lost_f} = pin_f_r;

	// Tenth-second tick; long count is a parameter to shorten in simulation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 24'h000000;
		end else if (div_r == 24'(TICK_LEN - 1)) begin
			div_r <= 24'h000000;
		end else begin
			div_r <= div_r + 24'h000001;
		end
	end
	assign tick = div_r == 24'(TICK_LEN - 1);

	// Monitored conditions and their durations
	always_comb begin
		cond = '0;
		cond[EV_PRE]  = out_current > lima_r[15:0]; // R1
		cond[EV_INP]  = ph_sel[1] && in_lost_f; // R2 R3
		cond[EV_OUTP] = (ph_sel[0] && out_lost_f && out_current > lima_r[31:16])
			|| (limb_r[31:16] != COEF_OFF
			&& 32'(phase_max) * 32'h64 > 32'(phase_min) * 32'(limb_r[31:16])); // R4 R5
		cond[EV_PID]  = pid_act != 2'h0
			&& pid_feedback < ((pid_lvl > pid_max) ? pid_max : pid_lvl); // R7
		cond[EV_SER]  = timb_r[31:16] != 16'h0000 && ser_silent_f; // R9
		cond[EV_KEY]  = key_silent_f; // R10
		cond[EV_NVS]  = nvs_err_f; // R11
		cond[EV_OVL]  = ovl_md == 2'h2 && out_current >= limb_r[15:0]; // R12
		lim[EV_PRE]  = tima_r[31:16];
		lim[EV_INP]  = tima_r[15:0];
		lim[EV_OUTP] = (ph_sel[0] && out_lost_f) ? OPL_DELAY_T : IMB_DELAY_T;
		lim[EV_PID]  = timb_r[15:0];
		lim[EV_SER]  = timb_r[31:16];
		lim[EV_KEY]  = timc_r[15:0];
		lim[EV_NVS]  = 16'h0000;
		lim[EV_OVL]  = timc_r[31:16];
	end

	// One qualifying timer per condition
	genvar g;
	generate
		for (g = 0; g < NEV; g++) begin : g_tmr
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tim_r[g] <= 16'h0000;
				end else if (!cond[g]) begin
					tim_r[g] <= 16'h0000; // R16
				end else if (tick && tim_r[g] < lim[g]) begin
					tim_r[g] <= tim_r[g] + 16'h0001;
				end
			end
			assign ev[g] = cond[g] && tim_r[g] >= lim[g];
		end
	endgenerate

	// Feedback-loss level is the top control byte; zero leaves the check off
	// Latched protection outcomes, held until accepted reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_r <= '0;
		end else if (reset_cmd && !reset_locked_r) begin
			lat_r <= ev; // R17 set wins over reset
		end else begin
			lat_r <= lat_r | ev; // R17
		end
	end

	// Overcurrent/module fault counter and lockout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_cnt_r       <= 14'h0000;
			ocm_d_r        <= 1'b0;
			reset_locked_r <= 1'b0;
		end else begin
			ocm_d_r <= oc_f || mod_f;
			if ((oc_f || mod_f) && !ocm_d_r && oc_cnt_r != 14'h3fff) begin
				oc_cnt_r <= oc_cnt_r + 14'h0001; // R13
			end
			if (oc_cnt_r > oc_lim_r) begin
				reset_locked_r <= 1'b1; // R13 cleared only by power-on
			end
		end
	end

	// Classify latched events into fault/alarm and stop behaviour
	always_comb begin
		fault = lat_r[EV_INP] || lat_r[EV_OUTP] || lat_r[EV_OVL]; // R3 R4 R5 R12
		alarm = 1'b0;
		stop_r = STOP_NONE;
		case (pid_act) // R6
			2'h1: if (lat_r[EV_PID]) begin alarm = 1'b1; stop_r = STOP_HOLD; end
			2'h2: if (lat_r[EV_PID]) begin fault = 1'b1; stop_r = STOP_COAST; end
			2'h3: if (lat_r[EV_PID]) begin alarm = 1'b1; stop_r = STOP_RAMP; end
			default: ;
		endcase
		case (ser_act) // R8
			2'h0: if (lat_r[EV_SER]) begin fault = 1'b1; stop_r = STOP_COAST; end
			2'h1: if (lat_r[EV_SER]) alarm = 1'b1;
			default: if (lat_r[EV_SER]) begin alarm = 1'b1; stop_r = STOP_RAMP; end
		endcase
		case (key_act) // R10
			2'h0: if (lat_r[EV_KEY]) begin fault = 1'b1; stop_r = STOP_COAST; end
			2'h1: if (lat_r[EV_KEY]) fault = 1'b1;
			default: if (lat_r[EV_KEY]) begin fault = 1'b1; stop_r = STOP_RAMP; end
		endcase
		if (lat_r[EV_NVS]) begin // R11
			if (nvs_act) alarm = 1'b1;
			else begin fault = 1'b1; stop_r = STOP_COAST; end
		end
		// A coasting fault wins over any ramp or hold request
		if (lat_r[EV_INP] || lat_r[EV_OUTP] || lat_r[EV_OVL]
			|| (lat_r[EV_PID] && pid_act == 2'h2) || (lat_r[EV_SER] && ser_act == 2'h0)
			|| (lat_r[EV_KEY] && key_act == 2'h0) || (lat_r[EV_NVS] && !nvs_act)) begin
			stop_r = STOP_COAST; // R3 R4 R17
		end
	end

	// Code shown, faults before the pre-alarm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_r <= CODE_NONE;
		end else if (lat_r[EV_OUTP]) begin
			code_r <= CODE_OUTP;
		end else if (lat_r[EV_INP]) begin
			code_r <= CODE_INP;
		end else if (lat_r[EV_OVL]) begin
			code_r <= CODE_OVL;
		end else if (lat_r[EV_PRE]) begin
			code_r <= CODE_PRE; // R1
		end else begin
			code_r <= CODE_NONE;
		end
	end

	assign prealarm     = lat_r[EV_PRE]; // R1
	assign stop_mode    = stop_r;
	assign fault_code   = code_r;
	assign reply_enable = st_addr != 8'h00; // R15
	assign irq          = |(stat_r & mask_r);

	// Configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RST;
			lima_r   <= LIMA_RST;
			limb_r   <= LIMB_RST;
			tima_r   <= TIMA_RST;
			timb_r   <= TIMB_RST;
			timc_r   <= TIMC_RST;
			mask_r   <= '0;
			oc_lim_r <= OCLIM_RST;
		end else if (wr) begin
			case (paddr)
				A_CTRL: if (pwdata[7:0] <= ADDR_MAX) ctrl_r <= pwdata; // R14
				A_LIMA: lima_r <= pwdata;
				A_LIMB: limb_r <= pwdata;
				A_TIMA: tima_r <= pwdata;
				A_TIMB: timb_r <= pwdata;
				A_TIMC: timc_r <= pwdata;
				A_MASK: mask_r <= pwdata[NEV-1:0];
				A_CMD:  oc_lim_r <= (pwdata[29:16] > 14'h270f) ? oc_lim_r : pwdata[29:16];
				default: ;
			endcase
		end
	end

	// Sticky status; a read clears only what it reported, new events win
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
		end else if (rd && paddr == A_STAT) begin
			stat_r <= (stat_r & ~prdata[NEV-1:0]) | ev;
		end else begin
			stat_r <= stat_r | ev;
		end
	end

	// Read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				A_CTRL:  prdata <= ctrl_r;
				A_LIMA:  prdata <= lima_r;
				A_LIMB:  prdata <= limb_r;
				A_TIMA:  prdata <= tima_r;
				A_TIMB:  prdata <= timb_r;
				A_TIMC:  prdata <= timc_r;
				A_STAT:  prdata <= {24'h000000, stat_r};
				A_MASK:  prdata <= {24'h000000, mask_r};
				A_FAULT: prdata <= {14'h0000, reset_locked_r, fault, code_r, lat_r};
				A_CMD:   prdata <= {2'h0, oc_lim_r, 2'h0, oc_cnt_r};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
	assign pslverr = psel && penable && paddr > A_CMD;

	// Assertions
	chk_prealarm_hold: assert property (@(posedge pclk) disable iff (!presetn) // R1
		ev[EV_PRE] |=> prealarm) else $error("prealarm missed");
	chk_input_fault: assert property (@(posedge pclk) disable iff (!presetn) // R3
		ev[EV_INP] |=> fault && stop_mode == STOP_COAST) else $error("input loss");
	chk_timer_restart: assert property (@(posedge pclk) disable iff (!presetn) // R16
		!cond[EV_PRE] |=> tim_r[EV_PRE] == 16'h0000) else $error("timer kept");
	chk_fault_latch: assert property (@(posedge pclk) disable iff (!presetn) // R17
		fault && !reset_cmd |=> fault) else $error("fault dropped");
	chk_lock_reset: assert property (@(posedge pclk) disable iff (!presetn) // R13
		reset_locked_r |=> (lat_r & $past(lat_r)) == $past(lat_r)) else $error("locked reset");
	chk_broadcast_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R15
		ctrl_r[7:0] == 8'h00 |-> !reply_enable) else $error("broadcast reply");
	chk_ovl_mode: assert property (@(posedge pclk) disable iff (!presetn) // R12
		ovl_md != 2'h2 |-> !ev[EV_OVL]) else $error("overload mode");
	chk_serial_off: assert property (@(posedge pclk) disable iff (!presetn) // R9
		timb_r[31:16] == 16'h0000 |-> !ev[EV_SER]) else $error("serial off");
	chk_addr_range: assert property (@(posedge pclk) disable iff (!presetn) // R14
		ctrl_r[7:0] <= ADDR_MAX) else $error("address range");
	chk_store_coast: assert property (@(posedge pclk) disable iff (!presetn) // R11
		ev[EV_NVS] && !nvs_act |=> fault && stop_mode == STOP_COAST) else $error("store fault");
endmodule : drive_protection_supervisor
`default_nettype wire

// ---- sim/drive_side_model.sv ----
/*
 * Far-side model: power stage levels, serial host and keypad link health.
 * Assumes the bench calls its tasks just after a rising pclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_side_model (
	// Clock
	input  wire logic        pclk,
	// Measurements
	output logic [15:0]      out_current,
	output logic [15:0]      phase_max,
	output logic [15:0]      phase_min,
	output logic [15:0]      pid_feedback,
	output logic [15:0]      pid_max,
	// Detector levels
	output logic             in_phase_lost,
	output logic             out_phase_lost,
	output logic             serial_good,
	output logic             keypad_good,
	output logic             nvs_error,
	output logic             overcurrent_fault,
	output logic             module_fault
);
	// Balanced phases and healthy feedback keep those checks quiet
	assign phase_max = out_current;
	assign phase_min = out_current;
	assign pid_max = 16'h0064;
	assign pid_feedback = 16'h0050;
	assign module_fault = 1'b0;

	// Links alive, no load at power-up
	initial begin
		out_current = 16'h0000;
		in_phase_lost = 1'b0;
		out_phase_lost = 1'b0;
		serial_good = 1'b1;
		keypad_good = 1'b1;
		overcurrent_fault = 1'b0;
		nvs_error = 1'b0;
	end

	task store(input logic e);
		nvs_error <= e;
	endtask : store

	task load(input logic [15:0] c, input logic i, input logic o);
		out_current <= c;
		in_phase_lost <= i;
		out_phase_lost <= o;
	endtask : load

	task link(input logic s, input logic k);
		serial_good <= s;
		keypad_good <= k;
	endtask : link

	// Trip held four cycles, then quiet four, so the pin filter counts it once
	task trip();
		@(posedge pclk);
		overcurrent_fault <= 1'b1;
		repeat (4) @(posedge pclk);
		overcurrent_fault <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : trip
endmodule : drive_side_model
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the protection supervisor over APB.
 * Assumes zero-wait APB answers and a shortened tick of 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dps_pkg::*;
	localparam int unsigned TL = 4;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic [7:0]  paddr, fault_code;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, prealarm, alarm, fault, reply_enable, irq;
	logic [1:0]  stop_mode;
	logic [15:0] out_current, phase_max, phase_min, pid_feedback, pid_max;
	logic        in_phase_lost, out_phase_lost, serial_good, keypad_good;
	logic        nvs_error, overcurrent_fault, module_fault;
	int          n_errors, checks_done, cycles;

	drive_protection_supervisor #(.TICK_LEN(TL)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .out_current(out_current),
		.phase_max(phase_max), .phase_min(phase_min), .pid_feedback(pid_feedback),
		.pid_max(pid_max), .in_phase_lost(in_phase_lost), .out_phase_lost(out_phase_lost),
		.serial_good(serial_good), .keypad_good(keypad_good), .nvs_error(nvs_error),
		.overcurrent_fault(overcurrent_fault), .module_fault(module_fault),
		.prealarm(prealarm), .alarm(alarm), .fault(fault), .stop_mode(stop_mode),
		.fault_code(fault_code), .reply_enable(reply_enable), .irq(irq));
	drive_side_model ps (.pclk(pclk), .out_current(out_current), .phase_max(phase_max),
		.phase_min(phase_min), .pid_feedback(pid_feedback), .pid_max(pid_max),
		.in_phase_lost(in_phase_lost), .out_phase_lost(out_phase_lost),
		.serial_good(serial_good), .keypad_good(keypad_good), .nvs_error(nvs_error),
		.overcurrent_fault(overcurrent_fault), .module_fault(module_fault));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// Hang guard, far above the expected four hundred or so cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	// Setup, access, then release once pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc

	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{n_errors, checks_done, cycles} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and unmapped word
		rdc(A_CTRL, CTRL_RST);
		rdc(A_LIMA, LIMA_RST);
		rdc(A_LIMB, LIMB_RST);
		rdc(A_TIMA, TIMA_RST);
		rdc(A_TIMB, TIMB_RST);
		rdc(A_TIMC, TIMC_RST);
		chk1(reply_enable, 1'b1);
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk1(err, 1'b1);
		// Station address range and broadcast silence
		apb(1'b1, A_CTRL, {CTRL_RST[31:8], 8'hf8});
		rdc(A_CTRL, CTRL_RST);
		apb(1'b1, A_CTRL, {CTRL_RST[31:8], 8'h00});
		chk1(reply_enable, 1'b0);
		apb(1'b1, A_CTRL, {CTRL_RST[31:8], ADDR_MAX});
		chk1(reply_enable, 1'b1);
		// Pre-alarm: an early drop must restart the delay
		apb(1'b1, A_TIMA, 32'h0003_0003);
		ps.load(16'h00aa, 1'b0, 1'b0);
		cyc(6);
		ps.load(16'h0000, 1'b0, 1'b0);
		cyc(4);
		ps.load(16'h00aa, 1'b0, 1'b0);
		cyc(6);
		chk1(prealarm, 1'b0);
		repeat (40) if (prealarm !== 1'b1) @(posedge pclk);
		#1;
		chk1(prealarm, 1'b1);
		chk({24'h0, fault_code}, {24'h0, CODE_PRE});
		chk1(irq, 1'b0);
		ps.load(16'h0000, 1'b0, 1'b0);
		apb(1'b1, A_MASK, 32'h0000_0001);
		chk1(irq, 1'b1);
		rdc(A_STAT, 32'h0000_0001);
		chk1(irq, 1'b0);
		// Select 1: input loss ignored, output loss trips after 5 s
		apb(1'b1, A_CTRL, {CTRL_RST[31:10], 2'h1, CTRL_RST[7:0]});
		ps.load(16'h003c, 1'b1, 1'b1);
		repeat (300) if (fault !== 1'b1) @(posedge pclk);
		#1;
		chk1(fault, 1'b1);
		chk({24'h0, fault_code}, {24'h0, CODE_OUTP});
		chk({30'h0, stop_mode}, {30'h0, STOP_COAST});
		ps.load(16'h0000, 1'b0, 1'b0);
		cyc(20);
		chk1(fault, 1'b1);
		apb(1'b1, A_CMD, 32'h0005_0001);
		cyc(2);
		chk1(fault, 1'b0);
		// Select 2: input loss trips after its delay
		apb(1'b1, A_CTRL, {CTRL_RST[31:10], 2'h2, CTRL_RST[7:0]});
		ps.load(16'h0000, 1'b1, 1'b0);
		repeat (40) if (fault !== 1'b1) @(posedge pclk);
		#1;
		chk({24'h0, fault_code}, {24'h0, CODE_INP});
		chk({30'h0, stop_mode}, {30'h0, STOP_COAST});
		ps.load(16'h0000, 1'b0, 1'b0);
		cyc(8);
		apb(1'b1, A_CMD, 32'h0005_0001);
		// Serial silence, default action alarms and keeps running
		apb(1'b1, A_TIMB, {16'h0002, TIMB_RST[15:0]});
		ps.link(1'b0, 1'b1);
		repeat (40) if (alarm !== 1'b1) @(posedge pclk);
		#1;
		chk1(alarm, 1'b1);
		chk1(fault, 1'b0);
		chk({30'h0, stop_mode}, {30'h0, STOP_NONE});
		ps.link(1'b1, 1'b1);
		rdc(A_STAT, 32'h0000_0016);
		// Store error with action 0: fault and coast, held through later steps
		ps.store(1'b1);
		repeat (20) if (fault !== 1'b1) @(posedge pclk);
		#1;
		chk1(fault, 1'b1);
		chk({30'h0, stop_mode}, {30'h0, STOP_COAST});
		ps.store(1'b0);
		// Six trips exceed the limit of five: reset refused
		repeat (6) ps.trip();
		cyc(2);
		rdc(A_CMD, 32'h0005_0006);
		apb(1'b1, A_CMD, 32'h0005_0001);
		apb(1'b0, A_FAULT, 32'h0000_0000);
		chk1(rd[17], 1'b1);
		chk1(fault, 1'b1);
		results();
	end
endmodule : testbench
`default_nettype wire
